// ### logic/data_memory_map.sv
`timescale 1ns/10ps
// Overview of operation
// - program store is 2048 words, 11-bit pc
// - flash byte image readable from 0x4000
// - cpu writes to mapped flash ignored
// - 0x00-0x3f is io, 0x40-0x13f sram
// - lock, config, calibration, id regions read-only
// - pointers predecrement before, postincrement after access
// - io instructions reach all 64 io locations
// - direct access only reaches 0x40-0xbf
// - indirect access decodes full 16-bit space
// - sram access completes in two cycles
// - 0x100-0x13f folds onto physical 0x00-0x3f
// - ram port uses linear physical byte address
// - ram data write stores at ram address
// - ram data read fetches byte at address
// - bit instructions only on io 0x00-0x1f
// - bit set/clear writes only the addressed bit, except at io 0x1f, where the ram data port stores the whole wdata byte
// - io also reachable at data 0x00-0x3f
module data_memory_map
  import dmem_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire cpu_req_t    cpu_req,
  input  wire logic [15:0] ptr_in,
  output cpu_rsp_t         cpu_rsp,
  input  wire logic [PC_W-1:0] pc,
  output logic      [15:0] fetch_word,
  input  wire logic        pgm_we,
  input  wire logic [PC_W-1:0] pgm_addr,
  input  wire logic [15:0] pgm_wdata,
  output io_req_t          io_req,
  input  wire logic [7:0]  io_rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } phase_t;

  typedef enum logic [3:0] {
    TGT_NONE  = 4'h0,
    TGT_IO    = 4'h1,
    TGT_RAM_PORT_DATA = 4'h2,
    TGT_RAM_PORT_ADDRESS = 4'h3,
    TGT_SRAM  = 4'h4,
    TGT_LOCK  = 4'h5,
    TGT_CFG   = 4'h6,
    TGT_CAL   = 4'h7,
    TGT_DID   = 4'h8,
    TGT_FLASH = 4'h9
  } target_t;

  typedef struct packed {
    phase_t     phase;
    target_t    tgt;
    logic       write;
    logic       bit_test;
    logic [2:0] bit_num;
    logic [1:0] nv_idx;
    logic [7:0] ram_addr;
    logic [7:0] io_data;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [15:0]        eff_addr;
  logic [15:0]        ptr_dec;
  logic               refuse;
  logic               sram_we;
  logic [SRAM_AW-1:0] sram_addr;
  logic [7:0]         sram_wdata;
  logic [7:0]         sram_rdata;
  logic [7:0]         flash_byte;
  logic [7:0]         nv_byte;
  logic [7:0]         rdata_mux;
  target_t            tgt_dec;
  logic               in_range;
  logic               ram_port_data_write;
  logic               ram_port_data_read;

  assign ptr_dec = ptr_in - 16'h0001;

  // predecrement uses the lowered pointer as the address
  always_comb begin
    eff_addr = cpu_req.addr;
    if (cpu_req.mode == MODE_PREDEC) begin
      eff_addr = ptr_dec;
    end else if (cpu_req.mode == MODE_INDIRECT ||
                 cpu_req.mode == MODE_POSTINC) begin
      eff_addr = ptr_in;
    end else if (cpu_req.mode == MODE_IO ||
                 cpu_req.mode == MODE_IO_BIT) begin
      eff_addr = {10'h000, cpu_req.addr[IO_AW-1:0]};
    end
  end

  // decode is refused, not folded, when direct or bit addressing
  // falls outside the window that the instruction can reach
  always_comb begin
    refuse = 1'b0;
    if (cpu_req.mode == MODE_DIRECT &&
        (cpu_req.addr < SRAM_FIRST || cpu_req.addr > DIRECT_LAST)) begin
      refuse = 1'b1;
    end
    if (cpu_req.mode == MODE_IO_BIT &&
        cpu_req.addr[IO_AW-1:0] > BIT_IO_LAST) begin
      refuse = 1'b1;
    end
  end

  always_comb begin
    tgt_dec = TGT_NONE;
    if (eff_addr <= IO_LAST) begin
      if (eff_addr[IO_AW-1:0] == RAM_DATA_IO) begin
        tgt_dec = TGT_RAM_PORT_DATA;
      end else if (eff_addr[IO_AW-1:0] == RAM_ADDR_IO) begin
        tgt_dec = TGT_RAM_PORT_ADDRESS;
      end else begin
        tgt_dec = TGT_IO;
      end
    end else if (eff_addr <= SRAM_LAST) begin
      tgt_dec = TGT_SRAM;
    end else if (eff_addr >= LOCK_FIRST && eff_addr <= LOCK_LAST) begin
      tgt_dec = TGT_LOCK;
    end else if (eff_addr >= CFG_FIRST && eff_addr <= CFG_LAST) begin
      tgt_dec = TGT_CFG;
    end else if (eff_addr >= CAL_FIRST && eff_addr <= CAL_LAST) begin
      tgt_dec = TGT_CAL;
    end else if (eff_addr >= DID_FIRST && eff_addr <= DID_LAST) begin
      tgt_dec = TGT_DID;
    end else if (eff_addr >= FLASH_FIRST && eff_addr <= FLASH_LAST) begin
      tgt_dec = TGT_FLASH;
    end
  end

  assign in_range    = cpu_req.valid && !refuse &&
                       state_reg.phase == ST_IDLE;
  assign ram_port_data_write = in_range && cpu_req.write && tgt_dec == TGT_RAM_PORT_DATA;
  assign ram_port_data_read  = in_range && !cpu_req.write && tgt_dec == TGT_RAM_PORT_DATA;

  // sram port shared by cpu decode (virtual) and ram port (physical)
  always_comb begin
    sram_we    = 1'b0;
    sram_addr  = eff_addr[SRAM_AW-1:0];
    sram_wdata = cpu_req.wdata;
    if (tgt_dec == TGT_RAM_PORT_DATA) begin
      sram_addr = state_reg.ram_addr;
    end
    if (in_range && cpu_req.write &&
        (tgt_dec == TGT_SRAM || tgt_dec == TGT_RAM_PORT_DATA)) begin
      sram_we = 1'b1;
    end
  end

  sram_byte_store #(
    .DEPTH (SRAM_BYTES),
    .AW    (SRAM_AW)
  ) u_sram (
    .clk_sys (clk_sys),
    .we      (sram_we),
    .addr    (sram_addr),
    .wdata   (sram_wdata),
    .rdata   (sram_rdata)
  );

  flash_word_store #(
    .WORDS (PROG_WORDS),
    .AW    (PC_W)
  ) u_flash (
    .clk_sys    (clk_sys),
    .pgm_we     (pgm_we),
    .pgm_addr   (pgm_addr),
    .pgm_wdata  (pgm_wdata),
    .pc         (pc),
    .fetch_word (fetch_word),
    .byte_addr  (eff_addr[PC_W:0]),
    .byte_data  (flash_byte)
  );

  // io bus request; bit ops carry a one-hot mask so the peripheral
  // touches only that bit and w1c flags elsewhere stay intact
  always_comb begin
    io_req       = '0;
    io_req.addr  = eff_addr[IO_AW-1:0];
    io_req.wdata = cpu_req.wdata;
    io_req.wmask = 8'hff;
    if (in_range && tgt_dec == TGT_IO) begin
      io_req.sel   = 1'b1;
      io_req.write = cpu_req.write;
      if (cpu_req.mode == MODE_IO_BIT) begin
        io_req.write = cpu_req.bit_op != BITOP_TEST;
        io_req.wmask = 8'h01 << cpu_req.bit_num;
        io_req.wdata = (cpu_req.bit_op == BITOP_SET) ? 8'hff : 8'h00;
      end
    end
  end

  always_comb begin
    case (state_reg.nv_idx)
      2'h0: nv_byte = DEVICE_ID0;
      2'h1: nv_byte = DEVICE_ID1;
      2'h2: nv_byte = DEVICE_ID2;
      default: nv_byte = DEVICE_ID3;
    endcase
    rdata_mux = 8'h00;
    case (state_reg.tgt)
      TGT_IO:    rdata_mux = state_reg.io_data;
      TGT_RAM_PORT_DATA: rdata_mux = sram_rdata;
      TGT_RAM_PORT_ADDRESS: rdata_mux = state_reg.ram_addr;
      TGT_SRAM:  rdata_mux = sram_rdata;
      TGT_LOCK:  rdata_mux = LOCK_RESET;
      TGT_CFG:   rdata_mux = CFG_RESET;
      TGT_CAL:   rdata_mux = CAL_RESET;
      TGT_DID:   rdata_mux = nv_byte;
      TGT_FLASH: rdata_mux = flash_byte;
      default:   rdata_mux = 8'h00;
    endcase
  end

  // two-cycle access: request then data
  always_comb begin
    state_next = state_reg;
    case (state_reg.phase)
      ST_IDLE: begin
        if (in_range) begin
          state_next.phase    = ST_DATA;
          state_next.tgt      = tgt_dec;
          state_next.write    = cpu_req.write;
          state_next.bit_test = cpu_req.mode == MODE_IO_BIT &&
                                cpu_req.bit_op == BITOP_TEST;
          state_next.bit_num  = cpu_req.bit_num;
          state_next.nv_idx   = eff_addr[1:0];
          state_next.io_data  = io_rdata;
          if (cpu_req.write && tgt_dec == TGT_RAM_PORT_ADDRESS) begin
            state_next.ram_addr = cpu_req.wdata;
          end
        end
      end
      ST_DATA: begin
        state_next.phase = ST_IDLE;
      end
      default: state_next.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg       <= '0;
      state_reg.phase <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    cpu_rsp           = '0;
    cpu_rsp.refused   = cpu_req.valid && refuse &&
                        state_reg.phase == ST_IDLE;
    cpu_rsp.ready     = state_reg.phase == ST_DATA || cpu_rsp.refused;
    cpu_rsp.rdata     = state_reg.phase == ST_DATA && !state_reg.write ?
                        rdata_mux : 8'h00;
    cpu_rsp.skip      = state_reg.phase == ST_DATA && state_reg.bit_test &&
                        state_reg.io_data[state_reg.bit_num];
    cpu_rsp.ptr_we    = in_range && (cpu_req.mode == MODE_PREDEC ||
                                     cpu_req.mode == MODE_POSTINC);
    cpu_rsp.ptr_value = cpu_req.mode == MODE_PREDEC ?
                        ptr_dec : ptr_in + 16'h0001;
  end

  a_sram_two_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_range |=> cpu_rsp.ready)
    else $error("access did not finish in two cycles");

  a_direct_refused: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cpu_req.valid && cpu_req.mode == MODE_DIRECT &&
     cpu_req.addr > DIRECT_LAST && state_reg.phase == ST_IDLE)
    |-> cpu_rsp.refused && !sram_we)
    else $error("direct access outside window accepted");

  a_fold_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tgt_dec == TGT_SRAM && eff_addr >= SRAM_FOLD)
    |-> sram_addr == SRAM_AW'(eff_addr - SRAM_FOLD))
    else $error("sram fold wrong");

  a_flash_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tgt_dec >= TGT_LOCK) |-> !sram_we && !io_req.sel)
    else $error("write reached read-only region");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.phase == ST_DATA && state_reg.tgt == TGT_NONE)
    |-> cpu_rsp.rdata == 8'h00)
    else $error("reserved read not zero");

  a_bit_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
    io_req.sel && cpu_req.mode == MODE_IO_BIT |->
    io_req.addr <= BIT_IO_LAST)
    else $error("bit op above io 0x1f");

  a_bit_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
    io_req.sel && cpu_req.mode == MODE_IO_BIT |->
    $onehot(io_req.wmask))
    else $error("bit op touches several bits");

  a_ram_port_data_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ram_port_data_write |-> sram_we && sram_addr == state_reg.ram_addr)
    else $error("ram port write misdirected");

  a_ram_port_data_fetch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ram_port_data_read ##1 1'b1 |-> cpu_rsp.rdata == sram_rdata)
    else $error("ram port read wrong");

  a_predec_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cpu_rsp.ptr_we && cpu_req.mode == MODE_PREDEC |->
    eff_addr == cpu_rsp.ptr_value && eff_addr + 16'h0001 == ptr_in)
    else $error("predecrement address not lowered pointer");

  a_postinc_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cpu_rsp.ptr_we && cpu_req.mode == MODE_POSTINC |->
    eff_addr == ptr_in && cpu_rsp.ptr_value == ptr_in + 16'h0001)
    else $error("postincrement address not old pointer");

  a_io_reach: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_range && cpu_req.mode == MODE_IO |->
    tgt_dec inside {TGT_IO, TGT_RAM_PORT_DATA, TGT_RAM_PORT_ADDRESS})
    else $error("io instruction left io space");

  a_ram_port_phys: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_range && tgt_dec == TGT_RAM_PORT_DATA |->
    sram_addr == state_reg.ram_addr)
    else $error("ram port address remapped");

  a_refuse_no_effect: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cpu_rsp.refused |-> !sram_we && !io_req.sel && !cpu_rsp.ptr_we)
    else $error("refused access had an effect");

  a_reserved_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_range && tgt_dec == TGT_NONE |-> !sram_we && !io_req.sel)
    else $error("reserved write took effect");
endmodule // data_memory_map

// ### logic/dmem_pkg.sv
package dmem_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 16;
  localparam int          PROG_WORDS    = 2048;
  localparam int          PC_W          = 11;
  localparam int          SRAM_BYTES    = 256;
  localparam int          SRAM_AW       = 8;
  localparam int          IO_LOCS       = 64;
  localparam int          IO_AW         = 6;
  localparam logic [15:0] IO_LAST       = 16'h003f;
  localparam logic [15:0] SRAM_FIRST    = 16'h0040;
  localparam logic [15:0] SRAM_LAST     = 16'h013f;
  localparam logic [15:0] SRAM_FOLD     = 16'h0100;
  localparam logic [15:0] DIRECT_LAST   = 16'h00bf;
  localparam logic [15:0] LOCK_FIRST    = 16'h3f00;
  localparam logic [15:0] LOCK_LAST     = 16'h3f01;
  localparam logic [15:0] CFG_FIRST     = 16'h3f40;
  localparam logic [15:0] CFG_LAST      = 16'h3f41;
  localparam logic [15:0] CAL_FIRST     = 16'h3f80;
  localparam logic [15:0] CAL_LAST      = 16'h3f81;
  localparam logic [15:0] DID_FIRST     = 16'h3fc0;
  localparam logic [15:0] DID_LAST      = 16'h3fc3;
  localparam logic [15:0] FLASH_FIRST   = 16'h4000;
  localparam logic [15:0] FLASH_LAST    = 16'h47ff;
  localparam logic [5:0]  RAM_DATA_IO   = 6'h1f;
  localparam logic [5:0]  RAM_ADDR_IO   = 6'h20;
  localparam logic [5:0]  BIT_IO_LAST   = 6'h1f;
  localparam logic [7:0]  LOCK_RESET    = 8'hff;
  localparam logic [7:0]  CFG_RESET     = 8'hff;
  localparam logic [7:0]  CAL_RESET     = 8'h00;
  localparam logic [7:0]  DEVICE_ID0    = 8'h5a;
  localparam logic [7:0]  DEVICE_ID1    = 8'h01;
  localparam logic [7:0]  DEVICE_ID2    = 8'h02;
  localparam logic [7:0]  DEVICE_ID3    = 8'h03;

  typedef enum logic [2:0] {
    MODE_DIRECT   = 3'h0,
    MODE_INDIRECT = 3'h1,
    MODE_PREDEC   = 3'h2,
    MODE_POSTINC  = 3'h3,
    MODE_IO       = 3'h4,
    MODE_IO_BIT   = 3'h5
  } access_mode_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } pointer_sel_t;

  typedef enum logic [1:0] {
    BITOP_SET   = 2'h0,
    BITOP_CLEAR = 2'h1,
    BITOP_TEST  = 2'h2
  } bit_op_t;

  typedef struct packed {
    logic         valid;
    logic         write;
    access_mode_t mode;
    pointer_sel_t ptr;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    bit_op_t      bit_op;
    logic [2:0]   bit_num;
  } cpu_req_t;

  typedef struct packed {
    logic        ready;
    logic        refused;
    logic [7:0]  rdata;
    logic        skip;
    logic        ptr_we;
    logic [15:0] ptr_value;
  } cpu_rsp_t;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } io_req_t;
endpackage

// ### logic/flash_word_store.sv
`timescale 1ns/10ps
module flash_word_store
  import dmem_pkg::*;
#(
  parameter int WORDS = PROG_WORDS,
  parameter int AW    = PC_W
) (
  input  wire logic          clk_sys,
  input  wire logic          pgm_we,
  input  wire logic [AW-1:0] pgm_addr,
  input  wire logic [15:0]   pgm_wdata,
  input  wire logic [AW-1:0] pc,
  output logic      [15:0]   fetch_word,
  input  wire logic [AW:0]   byte_addr,
  output logic      [7:0]    byte_data
);
  if (WORDS != (1 << AW)) begin : g_bad_words
    $error("flash words must equal 2**AW");
  end

  logic [15:0] mem [WORDS];
  logic [15:0] word_q;
  logic        hi_q;

  // only the external programming port may write
  always_ff @(posedge clk_sys) begin
    if (pgm_we) begin
      mem[pgm_addr] <= pgm_wdata;
    end
    fetch_word <= mem[pc];
    word_q     <= mem[byte_addr[AW:1]];
    hi_q       <= byte_addr[0];
  end

  // little-endian byte image of the word
  assign byte_data = hi_q ? word_q[15:8] : word_q[7:0];
endmodule // flash_word_store

// ### logic/sram_byte_store.sv
`timescale 1ns/10ps
module sram_byte_store
  import dmem_pkg::*;
#(
  parameter int DEPTH = SRAM_BYTES,
  parameter int AW    = SRAM_AW
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("sram depth must equal 2**AW");
  end

  // contents hold no reset: the array is undefined until written
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // sram_byte_store

// ### sim/io_peripheral_model.sv
`timescale 1ns/10ps
module io_peripheral_model
  import dmem_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire io_req_t io_req,
  output logic [7:0]   io_rdata
);
  logic [7:0] regs [IO_LOCS];

  initial begin
    for (int i = 0; i < IO_LOCS; i++) regs[i] = 8'h00;
  end

  // only masked bits change, so neighbouring flags keep their value
  always @(posedge clk_sys) begin
    if (io_req.sel && io_req.write)
      regs[io_req.addr] <= (regs[io_req.addr] & ~io_req.wmask) |
                           (io_req.wdata & io_req.wmask);
  end

  // unselected: inverted value, so a stray sample never looks right
  assign io_rdata = io_req.sel ? regs[io_req.addr] : ~regs[io_req.addr];
endmodule // io_peripheral_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dmem_pkg::*;
  localparam logic [15:0] ro_addr [11] = '{LOCK_FIRST, CFG_FIRST,
    CAL_FIRST, DID_FIRST, DID_FIRST + 16'h1, DID_FIRST + 16'h2, DID_LAST,
    16'h0140, 16'h3f02, 16'h4800, 16'hffff};
  localparam logic [7:0] ro_exp [11] = '{LOCK_RESET, CFG_RESET,
    CAL_RESET, DEVICE_ID0, DEVICE_ID1, DEVICE_ID2, DEVICE_ID3,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic            clk_sys;
  logic            rst_b;
  logic            pgm_we;
  cpu_req_t        req;
  cpu_rsp_t        rsp;
  io_req_t         io_req;
  logic [7:0]      io_rdata;
  logic [15:0]     ptr_in;
  logic [15:0]     fetch_word;
  logic [15:0]     pgm_wdata;
  logic [15:0]     lfsr;
  logic [15:0]     rd;
  logic [15:0]     got_pv;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] pgm_addr;
  logic [PC_W-1:0] wa;
  logic [7:0]      p;
  logic            got_ref;
  logic            got_pwe;
  logic            got_skip;
  bit_op_t         bop;
  logic [2:0]      bnum;
  int              fail_count;
  int              tests_run;
  int              lat;
  int              cycles = 0;

  data_memory_map dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .cpu_req(req), .ptr_in(ptr_in),
    .cpu_rsp(rsp), .pc(pc), .fetch_word(fetch_word), .pgm_we(pgm_we),
    .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata), .io_req(io_req),
    .io_rdata(io_rdata)
  );

  io_peripheral_model periph (
    .clk_sys(clk_sys), .io_req(io_req), .io_rdata(io_rdata)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // physical 0x00-0x3f sits behind the folded window at 0x100
  function automatic logic [15:0] virt_of(input logic [7:0] a);
    return (a < 8'h40) ? 16'h0100 + 16'(a) : 16'(a);
  endfunction

  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge after ready or refused is seen
  task automatic access(input access_mode_t m, input logic w,
                        input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, w, m, PTR_Z, a, d, bop, bnum};
    // indirect modes take their address from the pointer, not req.addr
    if (m == MODE_PREDEC)
      ptr_in <= a + 16'h0001;
    else if (m == MODE_INDIRECT || m == MODE_POSTINC)
      ptr_in <= a;
    lat = 0;
    @(negedge clk_sys);
    got_pwe = rsp.ptr_we;
    got_pv = rsp.ptr_value;
    while (rsp.ready !== 1'b1 && rsp.refused !== 1'b1 && lat < 8) begin
      @(negedge clk_sys);
      lat++;
    end
    got_ref = rsp.refused;
    got_skip = rsp.skip;
    rd = {8'h00, rsp.rdata};
    if (got_ref !== 1'b1) check("latency", 16'h0001, 16'(lat));
    @(posedge clk_sys);
    req.valid <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    ptr_in = 16'h0000;
    pc = '0;
    pgm_we = 1'b0;
    pgm_addr = '0;
    pgm_wdata = 16'h0000;
    lfsr = 16'h52a0;
    bop = BITOP_SET;
    bnum = 3'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : (i == 2) ? 8'h40 :
          (i == 3) ? 8'hff : lfsr[7:0];
      access(MODE_IO, 1'b1, {10'h000, RAM_ADDR_IO}, p);
      access(MODE_IO, 1'b1, {10'h000, RAM_DATA_IO}, lfsr[15:8]);
      access(MODE_INDIRECT, 1'b0, virt_of(p), 8'h00);
      check("sram via virtual", {8'h00, lfsr[15:8]}, rd);
      access(MODE_INDIRECT, 1'b1, virt_of(p), ~lfsr[15:8]);
      access(MODE_IO, 1'b0, {10'h000, RAM_DATA_IO}, 8'h00);
      check("ram port read", {8'h00, ~lfsr[15:8]}, rd);
    end
    $display("test ram port done");
    access(MODE_INDIRECT, 1'b1, 16'h00c0, 8'h22);
    access(MODE_DIRECT, 1'b1, 16'h00bf, 8'h5c);
    access(MODE_DIRECT, 1'b0, 16'h00bf, 8'h00);
    check("direct last", 16'h005c, rd);
    access(MODE_DIRECT, 1'b1, 16'h00c0, 8'h11);
    check("direct above refused", 16'h0001, 16'(got_ref));
    access(MODE_DIRECT, 1'b0, 16'h003f, 8'h00);
    check("direct below refused", 16'h0001, 16'(got_ref));
    access(MODE_INDIRECT, 1'b0, 16'h00c0, 8'h00);
    check("indirect upper sram", 16'h0022, rd);
    $display("test direct window done");
    for (int n = 0; n < 4; n++) begin
      lfsr = lfsr_next(lfsr);
      // the byte window ends at 0x47ff, so word 0x3ff is the last mapped
      wa = (n == 3) ? 11'h3ff : 11'(n * 37);
      @(posedge clk_sys);
      pgm_we <= 1'b1;
      pgm_addr <= wa;
      pgm_wdata <= lfsr;
      @(posedge clk_sys);
      pgm_we <= 1'b0;
      pc <= wa;
      access(MODE_INDIRECT, 1'b1, FLASH_FIRST + {4'h0, wa, 1'b0}, ~lfsr[7:0]);
      access(MODE_INDIRECT, 1'b0, FLASH_FIRST + {4'h0, wa, 1'b0}, 8'h00);
      check("flash low byte", {8'h00, lfsr[7:0]}, rd);
      access(MODE_INDIRECT, 1'b0, FLASH_FIRST + {4'h0, wa, 1'b1}, 8'h00);
      check("flash high byte", {8'h00, lfsr[15:8]}, rd);
      check("fetch word", lfsr, fetch_word);
    end
    $display("test flash done");
    for (int k = 0; k < 11; k++) begin
      access(MODE_INDIRECT, 1'b1, ro_addr[k], ~ro_exp[k]);
      access(MODE_INDIRECT, 1'b0, ro_addr[k], 8'h00);
      check("read only region", {8'h00, ro_exp[k]}, rd);
    end
    $display("test read only done");
    access(MODE_IO, 1'b1, 16'h003e, 8'ha7);
    access(MODE_INDIRECT, 1'b0, 16'h003e, 8'h00);
    check("io via data space", 16'h00a7, rd);
    access(MODE_INDIRECT, 1'b1, 16'h0005, 8'h81);
    bnum = 3'h4;
    access(MODE_IO_BIT, 1'b1, 16'h0005, 8'h00);
    access(MODE_IO, 1'b0, 16'h0005, 8'h00);
    check("bit set", 16'h0091, rd);
    bop = BITOP_CLEAR;
    bnum = 3'h0;
    access(MODE_IO_BIT, 1'b1, 16'h0005, 8'h00);
    access(MODE_IO, 1'b0, 16'h0005, 8'h00);
    check("bit clear", 16'h0090, rd);
    bop = BITOP_TEST;
    bnum = 3'h7;
    access(MODE_IO_BIT, 1'b0, 16'h0005, 8'h00);
    check("skip on set bit", 16'h0001, 16'(got_skip));
    bnum = 3'h0;
    access(MODE_IO_BIT, 1'b0, 16'h0005, 8'h00);
    check("no skip on clear bit", 16'h0000, 16'(got_skip));
    access(MODE_IO_BIT, 1'b0, 16'h0020, 8'h00);
    check("bit op high io refused", 16'h0001, 16'(got_ref));
    $display("test io bits done");
    for (int j = 0; j < 4; j++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_sys);
      ptr_in <= {4'h2, lfsr[11:0]};
      access(MODE_PREDEC, 1'b0, {4'h2, lfsr[11:0]} - 16'h1, 8'h00);
      check("predec write", 16'h0001, 16'(got_pwe));
      check("predec value", {4'h2, lfsr[11:0]} - 16'h1, got_pv);
      check("reserved read", 16'h0000, rd);
      access(MODE_POSTINC, 1'b0, {4'h2, lfsr[11:0]}, 8'h00);
      check("postinc value", {4'h2, lfsr[11:0]} + 16'h1, got_pv);
    end
    $display("test pointers done");
    complete_run();
  end
endmodule // tb_top
